// *** rtl/pag_defines.vh ***
// Purpose: constants for the peripheral access guard
// Assumes: 32-bit apb, byte addressed, one aligned word per register
// Notes: definitions only
`ifndef PAG_DEFINES_VH
`define PAG_DEFINES_VH

// register byte offsets on the configuration bus
`define PAG_OFS_KEY 8'h00
`define PAG_OFS_LOCK 8'h04
`define PAG_OFS_CLKEN 8'h08
`define PAG_OFS_CLKCFG 8'h0C

// unlock sequence codes, written in this order
`define PAG_KEY_CODE1 8'hA5
`define PAG_KEY_CODE2 8'hF1

// key state encoding, as read back from the key register
`define PAG_KST_LOCKED 2'h0
`define PAG_KST_HALF 2'h1
`define PAG_KST_OPEN 2'h2

// geometry of the guarded space
`define PAG_NPERIPH 16
`define PAG_NGROUP 4
`define PAG_PIDX_MSB 15
`define PAG_PIDX_LSB 12

// reset values
`define PAG_RST_LOCK 4'h0
`define PAG_RST_CLKEN 16'h0001
`define PAG_RST_SRC 3'h0
`define PAG_RST_DIV 8'h00

// clkcfg field positions
`define PAG_CFG_SRC_LSB 0
`define PAG_CFG_DIV_LSB 8
`define PAG_CFG_APB1_BIT 16
`define PAG_CFG_APBEFF_BIT 17

// timing: core rate and the fastest ahb rate at which apb may equal ahb
`define PAG_CORE_MHZ 250
`define PAG_APB_EQ_MAX_MHZ 50
// smallest ahb divide ratio (div field + 1) that keeps ahb at or below it
`define PAG_MIN_RATIO_APB_EQ \
    ((`PAG_CORE_MHZ + `PAG_APB_EQ_MAX_MHZ - 1) / `PAG_APB_EQ_MAX_MHZ)

`endif

// *** rtl/pag_guard.v ***
// Purpose: lock-and-key write protection and clock gating for peripherals
// Assumes: guarded bus and config bus both apb on core_clk
// Notes: peripheral index is gp_paddr[15:12], group is index / 4
// Notes: the guarded verdict is frozen at each transfer's setup edge
`timescale 1ns/1ps
`default_nettype none
`include "pag_defines.vh"

module pag_guard (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // configuration apb slave
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // guarded apb slave, from the bus fabric
    input wire [15:0] gp_paddr,
    input wire gp_psel,
    input wire gp_penable,
    input wire gp_pwrite,
    input wire [31:0] gp_pwdata,
    output wire [31:0] gp_prdata,
    output wire gp_pready,
    output wire gp_pslverr,
    // apb master toward the peripherals
    output wire [15:0] pp_psel,
    output wire pp_penable,
    output wire pp_pwrite,
    output wire [15:0] pp_paddr,
    output wire [31:0] pp_pwdata,
    input wire [31:0] pp_prdata,
    input wire pp_pready,
    input wire pp_pslverr,
    // clock control outputs
    output wire [15:0] periph_clk_en,
    output wire [2:0] ahb_src_sel,
    output wire ahb_tick,
    output wire apb_tick
);

    reg [1:0] key_state_r;
    reg [1:0] key_state_nxt;
    reg [3:0] lock_r;
    reg [15:0] clken_r;
    reg [2:0] src_r;
    reg [7:0] div_r;
    reg apb_eq_req_r;
    reg [31:0] prdata_r;
    reg [7:0] div_cnt_r;
    reg apb_phase_r;
    reg ahb_tick_r;
    reg apb_tick_r;
    reg deny_r;
    reg drop_r;

    wire cfg_setup;
    wire cfg_wr;
    wire cfg_hit;
    wire apb_eq_ok;
    wire apb_eq_eff;
    wire [3:0] pidx;
    wire [1:0] grp;
    wire periph_clk_on;
    wire grp_locked;
    wire drop_wr;
    wire deny;
    wire pass;
    wire gp_setup;
    wire deny_now;
    wire drop_now;
    wire key_wr;

    // address decode, used only for the mapping check behind pslverr
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `PAG_OFS_KEY) || (a == `PAG_OFS_LOCK) ||
                     (a == `PAG_OFS_CLKEN) || (a == `PAG_OFS_CLKCFG);
        end
    endfunction

    // smallest div+1 at which apb may equal ahb, as a 9-bit constant
    localparam integer MIN_RATIO_I = `PAG_MIN_RATIO_APB_EQ;
    localparam [8:0] MIN_RATIO = MIN_RATIO_I[8:0];

    // true when the ahb divide ratio keeps ahb slow enough
    function ratio_ok;
        input [7:0] d;
        begin
            ratio_ok = ({1'b0, d} + 9'd1) >= MIN_RATIO;
        end
    endfunction

    // one-hot select for a peripheral index
    function [15:0] onehot16;
        input [3:0] idx;
        begin
            onehot16 = 16'h0001 << idx;
        end
    endfunction

    // four neighbouring peripherals share one lock bit
    function [1:0] group_of;
        input [3:0] idx;
        begin
            group_of = idx[3:2];
        end
    endfunction

    assign cfg_setup = psel & ~penable;
    assign cfg_wr = psel & penable & pwrite;
    assign cfg_hit = mapped(paddr);
    // any write to the key register steps the sequencer
    assign key_wr = cfg_wr & (paddr == `PAG_OFS_KEY);

    // zero wait state; the read word was captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~cfg_hit;
    assign prdata = prdata_r;

    // apb may follow ahb one to one only if ahb is slow enough
    assign apb_eq_ok = ratio_ok(div_r);
    assign apb_eq_eff = apb_eq_req_r & apb_eq_ok;

    // key sequencer
    always @* begin
        key_state_nxt = key_state_r;
        if (key_wr) begin
            case (key_state_r)
                `PAG_KST_LOCKED: begin
                    if (pwdata[7:0] == `PAG_KEY_CODE1) begin
                        key_state_nxt = `PAG_KST_HALF;
                    end else begin
                        key_state_nxt = `PAG_KST_LOCKED;
                    end
                end
                `PAG_KST_HALF: begin
                    if (pwdata[7:0] == `PAG_KEY_CODE2) begin
                        key_state_nxt = `PAG_KST_OPEN;
                    end else if (pwdata[7:0] == `PAG_KEY_CODE1) begin
                        key_state_nxt = `PAG_KST_HALF;
                    end else begin
                        key_state_nxt = `PAG_KST_LOCKED;
                    end
                end
                `PAG_KST_OPEN: begin
                    key_state_nxt = `PAG_KST_LOCKED;
                end
                default: begin
                    key_state_nxt = `PAG_KST_LOCKED;
                end
            endcase
        end
    end

    // lock bits only move while the key sequencer is open
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_state_r <= `PAG_KST_LOCKED;
            lock_r <= `PAG_RST_LOCK;
            clken_r <= `PAG_RST_CLKEN;
            src_r <= `PAG_RST_SRC;
            div_r <= `PAG_RST_DIV;
            apb_eq_req_r <= 1'b0;
        end else begin
            key_state_r <= key_state_nxt;
            if (cfg_wr) begin
                case (paddr)
                    `PAG_OFS_LOCK: begin
                        if (key_state_r == `PAG_KST_OPEN) begin
                            lock_r <= pwdata[3:0];
                        end
                    end
                    `PAG_OFS_CLKEN: begin
                        clken_r <= pwdata[15:0];
                    end
                    `PAG_OFS_CLKCFG: begin
                        src_r <= pwdata[`PAG_CFG_SRC_LSB +: 3];
                        div_r <= pwdata[`PAG_CFG_DIV_LSB +: 8];
                        apb_eq_req_r <= pwdata[`PAG_CFG_APB1_BIT];
                    end
                    default: begin
                        lock_r <= lock_r;
                    end
                endcase
            end
        end
    end

    // read word captured in setup so prdata comes from a flip-flop
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (cfg_setup) begin
            case (paddr)
                `PAG_OFS_KEY: begin
                    prdata_r <= {30'h0000_0000, key_state_r};
                end
                `PAG_OFS_LOCK: begin
                    prdata_r <= {28'h000_0000, lock_r};
                end
                `PAG_OFS_CLKEN: begin
                    prdata_r <= {16'h0000, clken_r};
                end
                `PAG_OFS_CLKCFG: begin
                    prdata_r <= {14'h0000, apb_eq_eff, apb_eq_req_r,
                                 div_r, 5'h00, src_r};
                end
                default: begin
                    prdata_r <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ahb divider: one tick every div+1 cycles of core_clk
    // the count runs on core_clk; src only names the root to the fabric
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 8'h00;
            apb_phase_r <= 1'b0;
            ahb_tick_r <= 1'b0;
            apb_tick_r <= 1'b0;
        end else begin
            ahb_tick_r <= 1'b0;
            apb_tick_r <= 1'b0;
            if (div_cnt_r >= div_r) begin
                div_cnt_r <= 8'h00;
                ahb_tick_r <= 1'b1;
                apb_phase_r <= ~apb_phase_r;
                // apb ticks on every ahb tick or on every second one
                apb_tick_r <= apb_eq_eff | apb_phase_r;
            end else begin
                div_cnt_r <= div_cnt_r + 8'h01;
            end
        end
    end

    assign ahb_tick = ahb_tick_r;
    assign apb_tick = apb_tick_r;
    assign ahb_src_sel = src_r;
    assign periph_clk_en = clken_r;

    // guarded access path
    assign pidx = gp_paddr[`PAG_PIDX_MSB:`PAG_PIDX_LSB];
    assign grp = group_of(pidx);
    assign periph_clk_on = clken_r[pidx];
    assign grp_locked = lock_r[grp];
    assign gp_setup = gp_psel & ~gp_penable;
    // clock gating wins over locking: an unclocked peripheral errors
    assign deny_now = ~periph_clk_on;
    assign drop_now = periph_clk_on & gp_pwrite & grp_locked;

    // the verdict is frozen at the setup edge, so a lock or clock-enable
    // write landing mid-transfer cannot cut a peripheral's access short
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            deny_r <= 1'b0;
            drop_r <= 1'b0;
        end else if (gp_setup) begin
            deny_r <= deny_now;
            drop_r <= drop_now;
        end
    end

    assign deny = gp_psel & (gp_penable ? deny_r : deny_now);
    assign drop_wr = gp_psel & (gp_penable ? drop_r : drop_now);
    // reads never depend on the lock bits
    assign pass = gp_psel & ~deny & ~drop_wr;

    assign pp_psel = pass ? onehot16(pidx) : 16'h0000;
    assign pp_penable = pass & gp_penable;
    assign pp_pwrite = gp_pwrite;
    assign pp_paddr = gp_paddr;
    assign pp_pwdata = gp_pwdata;

    // dropped writes finish silently; denied accesses report an error
    assign gp_pready = pass ? pp_pready : 1'b1;
    assign gp_pslverr = pass ? pp_pslverr :
                        (deny & gp_penable);
    assign gp_prdata = pass ? pp_prdata : 32'h0000_0000;

endmodule // pag_guard
`default_nettype wire

// *** test/pag_guard_assertions.sv ***
// Purpose: port-level checks of pag_guard
// Assumes: one clock domain, async active-low reset
// Notes: bound from tb
`timescale 1ns/1ps
`default_nettype none
`include "pag_defines.vh"
module pag_guard_assertions (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // config bus
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    // guarded path
    input wire logic [15:0] gp_paddr,
    input wire logic gp_psel,
    input wire logic gp_penable,
    input wire logic gp_pwrite,
    input wire logic gp_pready,
    input wire logic gp_pslverr,
    input wire logic [15:0] pp_psel,
    // clock control
    input wire logic [15:0] periph_clk_en,
    input wire logic [2:0] ahb_src_sel,
    input wire logic ahb_tick,
    input wire logic apb_tick
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence gated_s;
        gp_psel && !periph_clk_en[gp_paddr[15:12]];
    endsequence
    cfg_ready_a: assert property (pready) else $error("pready low");
    gated_nosel_a: assert property (gated_s |-> pp_psel == 16'h0000)
        else $error("gated peripheral selected");
    gated_err_a: assert property (gated_s ##0 gp_penable |-> gp_pslverr && gp_pready)
        else $error("gated access not refused");
    read_pass_a: assert property (gp_psel && !gp_pwrite && periph_clk_en[gp_paddr[15:12]]
        |-> pp_psel == 16'h0001 << gp_paddr[15:12])
        else $error("read not passed");
    clken_hold_a: assert property (!(psel && penable && pwrite
        && paddr == `PAG_OFS_CLKEN) |=> $stable(periph_clk_en))
        else $error("clock enables moved");
    src_hold_a: assert property (!(psel && penable && pwrite
        && paddr == `PAG_OFS_CLKCFG) |=> $stable(ahb_src_sel))
        else $error("source moved");
    clken_reset_a: assert property ($rose(rst_n) |-> periph_clk_en == `PAG_RST_CLKEN)
        else $error("clock enable reset value");
    apb_sync_a: assert property (apb_tick |-> ahb_tick)
        else $error("apb tick off ahb");
endmodule // pag_guard_assertions
`default_nettype wire

// *** test/pag_periph_model.sv ***
// Purpose: sixteen one-word peripherals behind the guard
// Assumes: apb on core_clk
// Notes: wait states alternate so both quick and slow answers occur
`timescale 1ns/1ps
`default_nettype none
module pag_periph_model (
    // clock
    input wire logic core_clk,
    // peripheral bus
    input wire logic [15:0] pp_psel,
    input wire logic pp_penable,
    input wire logic pp_pwrite,
    input wire logic [15:0] pp_paddr,
    input wire logic [31:0] pp_pwdata,
    output logic [31:0] pp_prdata,
    output logic pp_pready,
    output logic pp_pslverr
);
    logic [31:0] mem [0:15] = '{default: 32'h0000_0000};
    logic slow_r = 1'b0;
    assign pp_pready = pp_penable && slow_r;
    assign pp_pslverr = 1'b0;
    // unselected: inverted word, so stale data never passes for a match
    assign pp_prdata = (|pp_psel) ? mem[pp_paddr[15:12]] : ~mem[pp_paddr[15:12]];
    always @(posedge core_clk) begin
        slow_r <= ~slow_r;
        if (pp_penable && pp_pready && pp_pwrite) mem[pp_paddr[15:12]] <= pp_pwdata;
    end
endmodule // pag_periph_model
`default_nettype wire

// *** test/tb.sv ***
// Purpose: self-checking bench for pag_guard
// Assumes: 250 MHz core_clk, model peripherals
// Notes: group 1 is the locked group in the random phase
`timescale 1ns/1ps
`default_nettype none
`include "pag_defines.vh"
module tb;
    logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic gp_psel = 1'b0, gp_penable = 1'b0, gp_pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [15:0] gp_paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, gp_pwdata = 32'h0000_0000, q, shadow [0:15];
    wire [31:0] prdata, gp_prdata, pp_prdata, pp_pwdata;
    wire [15:0] pp_psel, pp_paddr, periph_clk_en;
    wire [2:0] ahb_src_sel;
    wire pready, pslverr, gp_pready, gp_pslverr, pp_penable, pp_pwrite, pp_pready;
    wire pp_pslverr, ahb_tick, apb_tick;
    logic e;
    logic [3:0] i;
    integer seed = 32'hbdb48991, miscompares = 0, checks = 0;
    longint t0;
    always #2 core_clk = ~core_clk;
    pag_guard pag_guard_i (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gp_paddr(gp_paddr),
        .gp_psel(gp_psel), .gp_penable(gp_penable), .gp_pwrite(gp_pwrite),
        .gp_pwdata(gp_pwdata), .gp_prdata(gp_prdata), .gp_pready(gp_pready),
        .gp_pslverr(gp_pslverr), .pp_psel(pp_psel), .pp_penable(pp_penable),
        .pp_pwrite(pp_pwrite), .pp_paddr(pp_paddr), .pp_pwdata(pp_pwdata),
        .pp_prdata(pp_prdata), .pp_pready(pp_pready), .pp_pslverr(pp_pslverr),
        .periph_clk_en(periph_clk_en), .ahb_src_sel(ahb_src_sel),
        .ahb_tick(ahb_tick), .apb_tick(apb_tick));
    pag_periph_model pag_periph_model_i (.core_clk(core_clk), .pp_psel(pp_psel),
        .pp_penable(pp_penable), .pp_pwrite(pp_pwrite), .pp_paddr(pp_paddr),
        .pp_pwdata(pp_pwdata), .pp_prdata(pp_prdata), .pp_pready(pp_pready),
        .pp_pslverr(pp_pslverr));
    task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk) penable <= 1'b1;
        @(posedge core_clk iff pready === 1'b1) q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic gpa(input logic w, input logic [3:0] p, input logic [31:0] d);
        gp_psel <= 1'b1; gp_pwrite <= w; gp_paddr <= {p, 12'h000}; gp_pwdata <= d;
        @(posedge core_clk) gp_penable <= 1'b1;
        @(posedge core_clk iff gp_pready === 1'b1) q = gp_prdata;
        e = gp_pslverr;
        gp_psel <= 1'b0; gp_penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            miscompares++;
            $display("Error %0t: saw %h want %h", $time, s, x);
        end
    endtask
    task automatic gap(input logic apb, input logic [31:0] x);
        @(posedge core_clk iff (apb ? apb_tick : ahb_tick) === 1'b1) t0 = $time;
        @(posedge core_clk iff (apb ? apb_tick : ahb_tick) === 1'b1);
        chk(32'(($time - t0) / 4), x);
    endtask
    // locked group writes keep the old word
    function automatic logic [31:0] exp_wr(input logic [3:0] p, input logic [31:0] d);
        return (p[3:2] == 2'h1) ? shadow[p] : d;
    endfunction
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000 miscompares++;
        final_report;
    end
    initial begin
        foreach (shadow[k]) shadow[k] = 32'h0000_0000;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        cfg(0, `PAG_OFS_CLKEN, 0); chk(q, `PAG_RST_CLKEN);
        cfg(0, `PAG_OFS_KEY, 0); chk(q, `PAG_KST_LOCKED);
        cfg(0, 8'h10, 0); chk(q, 0); chk(32'(e), 1);
        cfg(1, `PAG_OFS_LOCK, 32'h0000_000F); cfg(0, `PAG_OFS_LOCK, 0); chk(q, 0);
        cfg(1, `PAG_OFS_KEY, `PAG_KEY_CODE1); cfg(0, `PAG_OFS_KEY, 0);
        chk(q, `PAG_KST_HALF);
        cfg(1, `PAG_OFS_KEY, 32'h0000_0033); cfg(0, `PAG_OFS_KEY, 0);
        chk(q, `PAG_KST_LOCKED);
        cfg(1, `PAG_OFS_KEY, `PAG_KEY_CODE1); cfg(1, `PAG_OFS_KEY, `PAG_KEY_CODE2);
        cfg(0, `PAG_OFS_KEY, 0); chk(q, `PAG_KST_OPEN);
        cfg(1, `PAG_OFS_LOCK, 32'h0000_0002); cfg(1, `PAG_OFS_KEY, 0);
        cfg(0, `PAG_OFS_KEY, 0); chk(q, `PAG_KST_LOCKED);
        cfg(1, `PAG_OFS_LOCK, 0); cfg(0, `PAG_OFS_LOCK, 0); chk(q, 2);
        gpa(1, 4'h9, 32'h0000_1234); gpa(0, 4'h9, 0); chk({q[30:0], e}, 1);
        cfg(1, `PAG_OFS_CLKEN, 32'h0000_FFFF);
        repeat (40) begin
            i = 4'($random(seed));
            gpa(1, i, $random(seed)); chk(32'(e), 0);
            shadow[i] = exp_wr(i, gp_pwdata);
            gpa(0, i, 0); chk(q, shadow[i]);
        end
        cfg(1, `PAG_OFS_CLKCFG, 32'h0001_0405); cfg(0, `PAG_OFS_CLKCFG, 0);
        chk(32'(q[17]), 1);
        chk(32'(ahb_src_sel), 5);
        gap(0, 5);
        gap(1, 5);
        cfg(1, `PAG_OFS_CLKCFG, 32'h0001_0302); cfg(0, `PAG_OFS_CLKCFG, 0);
        chk(32'(q[17]), 0);
        gap(1, 8);
        final_report;
    end
endmodule // tb
bind pag_guard pag_guard_assertions pag_guard_assertions_i (.core_clk(core_clk),
    .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .gp_paddr(gp_paddr), .gp_psel(gp_psel), .gp_penable(gp_penable),
    .gp_pwrite(gp_pwrite), .gp_pready(gp_pready), .gp_pslverr(gp_pslverr),
    .pp_psel(pp_psel), .periph_clk_en(periph_clk_en), .ahb_src_sel(ahb_src_sel),
    .ahb_tick(ahb_tick), .apb_tick(apb_tick));
`default_nettype wire
